//--- arb_pkg.sv
package arb_pkg;

  localparam int unsigned NUM_AGENTS    = 4;
  localparam int unsigned ID_W          = 2;
  localparam logic [1:0]  ROT_ID_RESET  = 2'h3;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Request strobe spacing, in clocks.
  localparam int unsigned STROBE_GAP_CLK    = 3;
  // Priority release to symmetric strobe, in clocks.
  localparam int unsigned PRI_RELEASE_CLK   = 2;
  // Reset release to first block-next-request sample, in clocks.
  localparam int unsigned RESET_SAMPLE_CLK  = 2;
  // Sample period while stalled or throttled, in clocks.
  localparam int unsigned STALL_SAMPLE_CLK  = 2;
  // Strobe to block-next-request sample in the free state, in clocks.
  localparam int unsigned FREE_SAMPLE_CLK   = 3;

  localparam int unsigned CNT_W = 3;

  typedef enum logic {
    OWN_IDLE,
    OWN_BUSY
  } own_state_t;

  typedef enum logic [1:0] {
    STALL_STALLED,
    STALL_THROTTLED,
    STALL_FREE
  } stall_state_t;

  // Observed bus arbitration lines, active high.
  typedef struct packed {
    logic [3:0] symmetric_bus_request;
    logic       priority_bus_request;
    logic       block_next_request;
    logic       request_strobe;
    logic       lock;
  } bus_obs_t;

  // Status shown to the local agent.
  typedef struct packed {
    logic [1:0]   rotating_id;
    own_state_t   own_state;
    stall_state_t stall_state;
  } arb_status_t;

endpackage

//--- stall_fsm.sv
`timescale 1ns/10ps
`default_nettype none

module stall_fsm (
  // Clock and reset.
  input  wire logic                  core_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  reinit_i,
  // Bus observation, already synchronised.
  input  wire logic                  block_next_request_i,
  input  wire logic                  strobe_seen_i,
  // State.
  output arb_pkg::stall_state_t      stall_state_o,
  output logic                       sample_o
);

  arb_pkg::stall_state_t        state;
  arb_pkg::stall_state_t        next_state;
  logic [arb_pkg::CNT_W-1:0]    cnt;
  logic [arb_pkg::CNT_W-1:0]    next_cnt;
  logic                         armed;
  logic                         next_armed;
  logic                         sample;

  // The first sample after reset falls two clocks after reset is seen inactive.
  localparam int unsigned            RESET_CNT_INT = arb_pkg::RESET_SAMPLE_CLK - 1;
  localparam logic [arb_pkg::CNT_W-1:0] RESET_CNT  = RESET_CNT_INT[arb_pkg::CNT_W-1:0];

  function automatic logic [arb_pkg::CNT_W-1:0] to_cnt(input int unsigned v);
    return v[arb_pkg::CNT_W-1:0];
  endfunction

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_armed = armed;
    sample     = 1'b0;
    if (reinit_i) begin
      next_state = arb_pkg::STALL_STALLED;
      next_cnt   = to_cnt(arb_pkg::RESET_SAMPLE_CLK - 1);
      next_armed = 1'b1;
    end else begin
      if (cnt != '0) begin
        next_cnt = cnt - to_cnt(1);
      end
      if (armed && cnt == '0) begin
        sample = 1'b1;
      end
      if (sample) begin
        case (state)
          arb_pkg::STALL_STALLED: begin
            next_state = block_next_request_i ? arb_pkg::STALL_STALLED : arb_pkg::STALL_THROTTLED;
          end
          arb_pkg::STALL_THROTTLED: begin
            next_state = block_next_request_i ? arb_pkg::STALL_STALLED : arb_pkg::STALL_FREE;
          end
          arb_pkg::STALL_FREE: begin
            next_state = block_next_request_i ? arb_pkg::STALL_STALLED : arb_pkg::STALL_FREE;
          end
          default: begin
            next_state = arb_pkg::STALL_STALLED;
          end
        endcase
        if (next_state == arb_pkg::STALL_FREE) begin
          next_armed = 1'b0;
        end else begin
          next_cnt   = to_cnt(arb_pkg::STALL_SAMPLE_CLK - 1);
          next_armed = 1'b1;
        end
      end
      // A strobe in the free state arms a sample three clocks later.
      if (strobe_seen_i && (state == arb_pkg::STALL_FREE) && (next_state == arb_pkg::STALL_FREE)) begin
        next_cnt   = to_cnt(arb_pkg::FREE_SAMPLE_CLK - 1);
        next_armed = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= arb_pkg::STALL_STALLED;
      cnt   <= RESET_CNT;
      armed <= 1'b1;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      armed <= next_armed;
    end
  end

  assign stall_state_o = state;
  assign sample_o      = sample;

endmodule

`default_nettype wire

//--- shared_bus_arbitration_stall.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// - Owner request drop picks the next owner next clock; identifier loads the clock after, state busy.
// - Owner may park while holding request and no other agent requests.
// - Owner may issue one unlocked strobe in the clock after priority asserts.
// - Priority request never alters the identifier or symmetric arbitration.
// - A strobe is driven only in a clock where the agent owns the bus; the code registers it from ownership in the clock before.
// - After sampling priority active, no new unlocked request from the next clock.
// - Successive request strobes are at least three clocks apart.
// - A locked sequence keeps the bus against the priority request.
// - During lock keep request and hold; drop both when done and others wait.
// - No symmetric strobe until two clocks after priority release.
// - On reset release block-next-request and enter the stalled state.
// - Block-next-request may assert after reset; first sample two clocks after reset.
// - Stalled or throttled samples block-next-request every second clock; stalled issues none.
// - Stalled with clear sample goes throttled allowing one transaction; set stays stalled.
// - Throttled clear sample goes free; set sample returns to stalled.
// - Free state samples only the third clock after a strobe.
// - Free set sample goes stalled; strobe in sample clock is the last.
// - Reset or re-initialise sets identifier three and ownership idle.
// - From idle grant to top requester next clock, busy the clock after.
module shared_bus_arbitration_stall (
  // Clock and reset.
  input  wire logic                  core_clk_i,
  input  wire logic                  resetn_i,
  // Agent configuration.
  input  wire logic [1:0]            agent_id_i,
  // Bus pins, active high, raw.
  input  wire logic [3:0]            symmetric_bus_request_i,
  input  wire logic                  priority_bus_request_i,
  input  wire logic                  block_next_request_i,
  input  wire logic                  request_strobe_i,
  input  wire logic                  lock_i,
  input  wire logic                  bus_reinitialise_i,
  // Local agent side.
  input  wire logic                  need_bus_i,
  input  wire logic                  txn_pending_i,
  input  wire logic                  txn_locked_i,
  input  wire logic                  lock_done_i,
  input  wire logic                  init_busy_i,
  // Bus drives.
  output logic                       symmetric_bus_request_o,
  output logic                       block_next_request_o,
  output logic                       block_next_request_oe_o,
  output logic                       request_strobe_o,
  output logic                       lock_o,
  // Status.
  output arb_pkg::arb_status_t       status_o,
  output logic                       owner_o
);

  // Three-stage synchronisers; a change counts when stages two and three agree.
  arb_pkg::bus_obs_t s1;
  arb_pkg::bus_obs_t s2;
  arb_pkg::bus_obs_t s3;
  arb_pkg::bus_obs_t obs;
  arb_pkg::bus_obs_t next_obs;
  logic [2:0]        rst_sync;
  logic [2:0]        next_rst_sync;

  always_comb begin
    next_obs = obs;
    for (int i = 0; i < $bits(arb_pkg::bus_obs_t); i++) begin
      if (s2[i] == s3[i]) begin
        next_obs[i] = s3[i];
      end
    end
    // A one-clock strobe never shows in two stages at once, so it is taken from stage three.
    next_obs.request_strobe = s3.request_strobe;
    next_rst_sync = {rst_sync[1:0], bus_reinitialise_i};
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1       <= '0;
      s2       <= '0;
      s3       <= '0;
      obs      <= '0;
      rst_sync <= '0;
    end else begin
      s1       <= {symmetric_bus_request_i, priority_bus_request_i, block_next_request_i,
                   request_strobe_i, lock_i};
      s2       <= s1;
      s3       <= s2;
      obs      <= next_obs;
      rst_sync <= next_rst_sync;
    end
  end

  logic reinit_seen;
  logic reinit_prev;
  logic reinit_rise;
  logic reinit_fall;
  assign reinit_seen = rst_sync[2] & rst_sync[1];
  assign reinit_rise = reinit_seen & ~reinit_prev;
  assign reinit_fall = ~reinit_seen & reinit_prev;

  // Round-robin pick starting one above the identifier.
  function automatic logic [1:0] rr_pick(input logic [1:0] rot, input logic [3:0] req);
    logic [1:0] cand;
    rr_pick = rot;
    for (int k = arb_pkg::NUM_AGENTS; k >= 1; k--) begin
      cand = rot + k[1:0];
      if (req[cand]) begin
        rr_pick = cand;
      end
    end
  endfunction

  // Ownership bookkeeping, identical in every agent.
  logic [1:0]          rot_id;
  logic [1:0]          next_rot_id;
  arb_pkg::own_state_t own;
  arb_pkg::own_state_t next_own;
  logic                pend;
  logic                next_pend;
  logic [1:0]          pend_id;
  logic [1:0]          next_pend_id;

  always_comb begin
    next_rot_id  = rot_id;
    next_own     = own;
    next_pend    = 1'b0;
    next_pend_id = pend_id;
    if (reinit_seen) begin
      next_rot_id = arb_pkg::ROT_ID_RESET;
      next_own    = arb_pkg::OWN_IDLE;
    end else if (pend) begin
      next_rot_id = pend_id;
      next_own    = arb_pkg::OWN_BUSY;
    end else if (own == arb_pkg::OWN_IDLE) begin
      if (obs.symmetric_bus_request != '0) begin
        next_pend    = 1'b1;
        next_pend_id = rr_pick(rot_id, obs.symmetric_bus_request);
      end
    end else if (!obs.symmetric_bus_request[rot_id]) begin
      // Owner released; priority request plays no part here.
      if (obs.symmetric_bus_request != '0) begin
        next_pend    = 1'b1;
        next_pend_id = rr_pick(rot_id, obs.symmetric_bus_request);
      end else begin
        next_own = arb_pkg::OWN_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rot_id      <= arb_pkg::ROT_ID_RESET;
      own         <= arb_pkg::OWN_IDLE;
      pend        <= 1'b0;
      pend_id     <= '0;
      reinit_prev <= 1'b0;
    end else begin
      rot_id      <= next_rot_id;
      own         <= next_own;
      pend        <= next_pend;
      pend_id     <= next_pend_id;
      reinit_prev <= reinit_seen;
    end
  end

  logic is_owner;
  assign is_owner = (own == arb_pkg::OWN_BUSY) && (rot_id == agent_id_i) && !pend;

  // Request stall machine.
  arb_pkg::stall_state_t stall_state;
  logic                  stall_sample;
  logic                  strobe_seen;
  logic                  post_reset;
  logic                  next_post_reset;
  logic                  bnr_q;
  logic                  next_bnr_q;
  assign strobe_seen = obs.request_strobe;

  stall_fsm u_stall (
    .core_clk_i           (core_clk_i),
    .resetn_i             (resetn_i),
    .reinit_i             (reinit_seen | reinit_fall),
    .block_next_request_i (obs.block_next_request | bnr_q),
    .strobe_seen_i        (strobe_seen),
    .stall_state_o        (stall_state),
    .sample_o             (stall_sample)
  );

  function automatic logic [arb_pkg::CNT_W-1:0] to_c(input int unsigned v);
    return v[arb_pkg::CNT_W-1:0];
  endfunction

  // Local drive state.
  logic                      req_q;
  logic                      next_req_q;
  logic                      gap;
  logic                      lock_q;
  logic                      next_lock_q;
  logic                      strobe_q;
  logic                      next_strobe_q;
  logic                      pri_prev;
  logic                      thr_used;
  logic                      next_thr_used;
  logic [arb_pkg::CNT_W-1:0] since_strobe;
  logic [arb_pkg::CNT_W-1:0] next_since_strobe;
  logic [arb_pkg::CNT_W-1:0] since_pri;
  logic [arb_pkg::CNT_W-1:0] next_since_pri;
  logic                      other_req;
  logic                      may_strobe;

  assign other_req = |(obs.symmetric_bus_request & ~(4'h1 << agent_id_i));

  always_comb begin
    next_req_q        = req_q;
    next_lock_q       = lock_q;
    next_strobe_q     = 1'b0;
    next_bnr_q        = 1'b0;
    next_thr_used     = thr_used;
    next_post_reset   = 1'b0;
    next_since_strobe = (since_strobe == to_c(arb_pkg::STROBE_GAP_CLK)) ? since_strobe
                        : since_strobe + to_c(1);
    next_since_pri    = (since_pri == to_c(arb_pkg::PRI_RELEASE_CLK)) ? since_pri
                        : since_pri + to_c(1);
    may_strobe        = 1'b0;
    if (reinit_seen) begin
      next_req_q        = 1'b0;
      next_lock_q       = 1'b0;
      next_since_strobe = to_c(arb_pkg::STROBE_GAP_CLK);
      next_thr_used     = 1'b0;
    end else begin
      if (reinit_fall) begin
        next_post_reset = 1'b1;
      end
      if (post_reset) begin
        next_bnr_q = init_busy_i;
      end else begin
        next_bnr_q = bnr_q & init_busy_i;
      end
      if (obs.priority_bus_request) begin
        next_since_pri = '0;
      end
      if (stall_state != arb_pkg::STALL_THROTTLED) begin
        next_thr_used = 1'b0;
      end
      // Priority seen this clock blocks unlocked strobes from next clock on.
      may_strobe = is_owner && txn_pending_i && (next_req_q | req_q)
                   && (since_strobe == to_c(arb_pkg::STROBE_GAP_CLK))
                   && !strobe_q
                   && (stall_state != arb_pkg::STALL_STALLED)
                   && !(stall_state == arb_pkg::STALL_THROTTLED && thr_used)
                   && (lock_q || !obs.priority_bus_request || !pri_prev)
                   && (lock_q || since_pri == to_c(arb_pkg::PRI_RELEASE_CLK));
      if (may_strobe) begin
        next_strobe_q     = 1'b1;
        next_since_strobe = '0;
        next_lock_q       = txn_locked_i | lock_q;
        if (stall_state == arb_pkg::STALL_THROTTLED) begin
          next_thr_used = 1'b1;
        end
      end
      if (lock_q && lock_done_i) begin
        next_lock_q = 1'b0;
        if (other_req) begin
          next_req_q = 1'b0;
        end
      end else if (!req_q) begin
        next_req_q = need_bus_i && !gap;
      end else if (is_owner && !lock_q && !next_lock_q) begin
        // Release after strobe if others wait, else park while needed.
        if ((may_strobe && other_req) || !need_bus_i) begin
          next_req_q = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_q        <= 1'b0;
      gap          <= 1'b0;
      lock_q       <= 1'b0;
      strobe_q     <= 1'b0;
      bnr_q        <= 1'b0;
      pri_prev     <= 1'b0;
      thr_used     <= 1'b0;
      post_reset   <= 1'b1;
      since_strobe <= to_c(arb_pkg::STROBE_GAP_CLK);
      since_pri    <= to_c(arb_pkg::PRI_RELEASE_CLK);
    end else begin
      req_q        <= next_req_q;
      gap          <= req_q & ~next_req_q;
      lock_q       <= next_lock_q;
      strobe_q     <= next_strobe_q;
      bnr_q        <= next_bnr_q;
      pri_prev     <= obs.priority_bus_request;
      thr_used     <= next_thr_used;
      post_reset   <= next_post_reset;
      since_strobe <= next_since_strobe;
      since_pri    <= next_since_pri;
    end
  end

  assign symmetric_bus_request_o = req_q;
  assign request_strobe_o        = strobe_q;
  assign lock_o                  = lock_q;
  assign block_next_request_o    = bnr_q;
  assign block_next_request_oe_o = bnr_q;
  assign owner_o                 = is_owner;
  assign status_o                = '{rotating_id: rot_id, own_state: own, stall_state: stall_state};

endmodule

`default_nettype wire

//--- arb_checker.sv
`timescale 1ns/10ps
`default_nettype none

module arb_checker (
  // Clock and reset.
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  // Observed inputs.
  input  wire logic [1:0]           agent_id_i,
  input  wire logic                 priority_bus_request_i,
  input  wire logic                 bus_reinitialise_i,
  // Design drives.
  input  wire logic                 symmetric_bus_request_o,
  input  wire logic                 block_next_request_o,
  input  wire logic                 request_strobe_o,
  input  wire logic                 lock_o,
  input  wire arb_pkg::arb_status_t status_o,
  input  wire logic                 owner_o
);
  wire logic [1:0] st;
  wire logic       busy;
  wire logic       rst_val;
  assign st      = status_o.stall_state;
  assign busy    = status_o.own_state == arb_pkg::OWN_BUSY;
  assign rst_val = status_o.rotating_id == arb_pkg::ROT_ID_RESET && !busy && st == arb_pkg::STALL_STALLED;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_reset_state: assert property ($rose(resetn_i) |-> rst_val)
    else $error("state after reset is not the initial state");
  a_reinit_state: assert property (bus_reinitialise_i [*6] |-> rst_val && !block_next_request_o)
    else $error("re-initialise did not clear the state");
  a_strobe_gap: assert property (request_strobe_o |=> !request_strobe_o [*2])
    else $error("strobes closer than three clocks");
  a_strobe_owner: assert property (request_strobe_o |-> owner_o || $past(owner_o))
    else $error("strobe without ownership");
  a_strobe_stall: assert property (request_strobe_o |->
    st != arb_pkg::STALL_STALLED || $past(st) != arb_pkg::STALL_STALLED)
    else $error("strobe while stalled");
  a_pri_block: assert property ((priority_bus_request_i && !lock_o) [*7] |-> !request_strobe_o)
    else $error("unlocked strobe under priority request");
  a_pri_release: assert property ($fell(priority_bus_request_i) |-> !request_strobe_o [*3])
    else $error("strobe too soon after priority release");
  a_lock_request: assert property (lock_o |-> symmetric_bus_request_o)
    else $error("hold line without request");
  a_id_busy: assert property (!bus_reinitialise_i && $changed(status_o.rotating_id) |-> busy)
    else $error("identifier changed without busy state");
  a_free_path: assert property ($changed(st) && st == arb_pkg::STALL_FREE |->
    $past(st) == arb_pkg::STALL_THROTTLED)
    else $error("free state entered not from throttled");
  a_stall_pace: assert property ($changed(st) && st == arb_pkg::STALL_THROTTLED |=> $stable(st))
    else $error("stall machine sampled on consecutive clocks");
  a_owner_match: assert property (owner_o |-> busy && status_o.rotating_id == agent_id_i)
    else $error("owner flag disagrees with state");
  a_owner_handoff: assert property (busy && status_o.rotating_id == agent_id_i && !owner_o |=>
    status_o.rotating_id != agent_id_i || !busy)
    else $error("released ownership was not handed on");
endmodule

bind shared_bus_arbitration_stall arb_checker chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .agent_id_i(agent_id_i),
  .priority_bus_request_i(priority_bus_request_i), .bus_reinitialise_i(bus_reinitialise_i),
  .symmetric_bus_request_o(symmetric_bus_request_o), .block_next_request_o(block_next_request_o),
  .request_strobe_o(request_strobe_o), .lock_o(lock_o), .status_o(status_o), .owner_o(owner_o));

`default_nettype wire

//--- bus_partner.sv
`timescale 1ns/10ps
`default_nettype none

module bus_partner (
  // Clock and reset.
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  // Device drives.
  input  wire logic [1:0]       agent_id_i,
  input  wire logic             dev_request_i,
  input  wire logic             dev_block_i,
  input  wire logic             dev_strobe_i,
  input  wire logic             dev_lock_i,
  // Far agent commands.
  input  wire logic [3:0]       other_request_i,
  input  wire logic             pri_request_i,
  // Observed bus.
  output var arb_pkg::bus_obs_t bus_o
);
  logic [2:0] pri_cnt, next_pri_cnt;
  logic [1:0] gap, next_gap;
  logic       pri_strobe, next_pri_strobe;
  logic       pri_done, next_pri_done;
  logic [3:0] req;

  // The priority agent strobes once, four clocks after raising its request, with the hold line low.
  always_comb begin
    req             = other_request_i;
    req[agent_id_i] = dev_request_i;
    bus_o           = {req, pri_request_i, dev_block_i, dev_strobe_i | pri_strobe, dev_lock_i};
    next_gap        = {gap[0], dev_strobe_i | pri_strobe};
    next_pri_cnt    = pri_request_i ? pri_cnt + {2'h0, pri_cnt != 3'h7} : 3'h0;
    next_pri_done   = pri_request_i && (pri_done || pri_strobe);
    next_pri_strobe = pri_request_i && pri_cnt >= 3'h3 && !dev_lock_i && !pri_done
                      && gap == 2'h0 && !(dev_strobe_i | pri_strobe);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pri_cnt    <= 3'h0;
      gap        <= 2'h0;
      pri_strobe <= 1'b0;
      pri_done   <= 1'b0;
    end else begin
      pri_cnt    <= next_pri_cnt;
      gap        <= next_gap;
      pri_strobe <= next_pri_strobe;
      pri_done   <= next_pri_done;
    end
  end
endmodule

`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam logic [1:0] SELF_ID = 2'h1;
  logic                 core_clk_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic                 reinit = 1'b0;
  logic                 need_bus = 1'b0;
  logic                 pending = 1'b0;
  logic                 locked = 1'b0;
  logic                 lock_done = 1'b0;
  logic                 init_busy = 1'b0;
  logic [3:0]           other_req = 4'h0;
  logic                 pri_req = 1'b0;
  arb_pkg::bus_obs_t    bus;
  arb_pkg::arb_status_t status_o;
  logic                 sym_req, bnr, bnr_oe, strobe, lock_o, owner_o;
  int                   err_total = 0;
  int                   total_checks = 0;
  int                   n;

  always #(arb_pkg::CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;

  shared_bus_arbitration_stall uut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .agent_id_i(SELF_ID),
    .symmetric_bus_request_i(bus.symmetric_bus_request), .priority_bus_request_i(bus.priority_bus_request),
    .block_next_request_i(bus.block_next_request), .request_strobe_i(bus.request_strobe),
    .lock_i(bus.lock), .bus_reinitialise_i(reinit), .need_bus_i(need_bus), .txn_pending_i(pending),
    .txn_locked_i(locked), .lock_done_i(lock_done), .init_busy_i(init_busy),
    .symmetric_bus_request_o(sym_req), .block_next_request_o(bnr), .block_next_request_oe_o(bnr_oe),
    .request_strobe_o(strobe), .lock_o(lock_o), .status_o(status_o), .owner_o(owner_o));

  bus_partner far (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .agent_id_i(SELF_ID), .dev_request_i(sym_req),
    .dev_block_i(bnr), .dev_strobe_i(strobe), .dev_lock_i(lock_o), .other_request_i(other_req),
    .pri_request_i(pri_req), .bus_o(bus));

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_bit(input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic check_stat(input logic [1:0] id, input arb_pkg::own_state_t own,
                            input arb_pkg::stall_state_t sst);
    total_checks++;
    if (status_o !== {id, own, sst}) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, {id, own, sst}, status_o);
    end
  endtask

  task automatic wait_for(input int k, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge core_clk_i);
      #1;
      cnt++;
      case (k)
        0: hit = status_o.stall_state === arb_pkg::STALL_FREE;
        1: hit = owner_o === 1'b1;
        2: hit = strobe === 1'b1;
        3: hit = lock_o === 1'b0;
        4: hit = status_o.rotating_id === 2'h2;
        default: hit = status_o.own_state === arb_pkg::OWN_BUSY;
      endcase
      if (!hit && cnt >= lim) begin
        err_total++;
        $display("wait %0d ran out at %0t", k, $time);
        stop_test();
      end
    end
  endtask

  task automatic stall_walk();
    @(negedge core_clk_i);
    init_busy = 1'b1;
    reinit = 1'b1;
    repeat (6) @(negedge core_clk_i);
    reinit = 1'b0;
    repeat (10) @(negedge core_clk_i);
    check_stat(2'h3, arb_pkg::OWN_IDLE, arb_pkg::STALL_STALLED);
    check_bit(1'b1, bnr);
    check_bit(1'b1, bnr_oe);
    init_busy = 1'b0;
    wait_for(0, 40, n);
    check_stat(2'h3, arb_pkg::OWN_IDLE, arb_pkg::STALL_FREE);
  endtask

  task automatic arb_walk();
    @(negedge core_clk_i);
    other_req[0] = 1'b1;
    need_bus = 1'b1;
    wait_for(5, 20, n);
    check_stat(2'h0, arb_pkg::OWN_BUSY, arb_pkg::STALL_FREE);
    check_bit(1'b1, sym_req);
    @(negedge core_clk_i);
    other_req[0] = 1'b0;
    wait_for(1, 20, n);
    check_stat(SELF_ID, arb_pkg::OWN_BUSY, arb_pkg::STALL_FREE);
    @(negedge core_clk_i);
    pending = 1'b1;
    wait_for(2, 30, n);
    check_bit(1'b1, owner_o);
    @(negedge core_clk_i);
    pending = 1'b0;
    repeat (12) @(negedge core_clk_i);
    check_bit(1'b1, owner_o);
  endtask

  task automatic pri_walk();
    @(negedge core_clk_i);
    pri_req = 1'b1;
    repeat (6) @(negedge core_clk_i);
    pending = 1'b1;
    n = 0;
    repeat (12) begin
      @(posedge core_clk_i);
      #1;
      n = n + int'(strobe === 1'b1);
    end
    check_bit(1'b0, n != 0);
    check_bit(1'b1, owner_o);
    check_stat(SELF_ID, arb_pkg::OWN_BUSY, arb_pkg::STALL_FREE);
    @(negedge core_clk_i);
    pri_req = 1'b0;
    wait_for(2, 40, n);
    check_bit(1'b1, n > 2);
    @(negedge core_clk_i);
    pending = 1'b0;
  endtask

  task automatic lock_walk();
    @(negedge core_clk_i);
    other_req[2] = 1'b1;
    locked = 1'b1;
    pending = 1'b1;
    wait_for(2, 30, n);
    @(negedge core_clk_i);
    pending = 1'b0;
    pri_req = 1'b1;
    repeat (8) @(negedge core_clk_i);
    check_bit(1'b1, lock_o);
    check_bit(1'b1, sym_req);
    pending = 1'b1;
    wait_for(2, 40, n);
    check_bit(1'b1, lock_o);
    @(negedge core_clk_i);
    pending = 1'b0;
    lock_done = 1'b1;
    wait_for(3, 40, n);
    check_bit(1'b0, sym_req);
    @(negedge core_clk_i);
    lock_done = 1'b0;
    locked = 1'b0;
    wait_for(4, 30, n);
    check_stat(2'h2, arb_pkg::OWN_BUSY, arb_pkg::STALL_FREE);
    repeat (8) @(negedge core_clk_i);
    pri_req = 1'b0;
  endtask

  task automatic reinit_walk();
    @(negedge core_clk_i);
    reinit = 1'b1;
    repeat (6) @(negedge core_clk_i);
    check_stat(2'h3, arb_pkg::OWN_IDLE, arb_pkg::STALL_STALLED);
    reinit = 1'b0;
  endtask

  initial begin
    repeat (20) @(negedge core_clk_i);
    check_stat(2'h3, arb_pkg::OWN_IDLE, arb_pkg::STALL_STALLED);
    check_bit(1'b0, bnr);
    resetn_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    stall_walk();
    arb_walk();
    pri_walk();
    lock_walk();
    reinit_walk();
    repeat (5) @(negedge core_clk_i);
    stop_test();
  end
endmodule

`default_nettype wire
